/* File: hw/sum_shift_consts.svh */
// constants of the summation and shift accumulator
`ifndef SUM_SHIFT_CONSTS_SVH
`define SUM_SHIFT_CONSTS_SVH
`define ADDR_RATIO_LO   8'hDE
`define ADDR_RATIO_HI   8'hDF
`define ADDR_SUM_CTRL   8'hE1
`define ADDR_SUM_B0     8'hE2
`define ADDR_SUM_B1     8'hE3
`define ADDR_SUM_B2     8'hE4
`define ADDR_SUM_B3     8'hE5
`define RST_RATIO_LO    8'h1B
`define RST_RATIO_HI    3'h6
`define RST_SUM_CTRL    8'h00
`define MODE_CPU        2'h0
`define MODE_SHIFT      2'h2
`define MODE_ACC        2'h1
`define MODE_ACC_SHIFT  2'h3
`define CNT_CPU_ADD     3'h2
`define CNT_CPU_SUB     3'h4
`define MOD_DIV_LAST    6'h3F
`define COUNT_BASE      9'h002
`endif

/* File: hw/sum_shift_pkg.sv */
// types of the summation and shift accumulator
package sum_shift_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  typedef struct packed {
    logic [7:0]  ratio_lo;
    logic [2:0]  ratio_hi;
    logic [7:0]  ctrl;
    logic [31:0] hold;
    logic [31:0] acc;
    logic [8:0]  cnt;
    logic        stopped;
    logic        pend;
    logic        invalid;
    logic [6:0]  aclk_cnt;
    logic [5:0]  mod_cnt;
    logic [10:0] dec_cnt;
    logic        strobe;
    logic [7:0]  rdata;
  } state_t;
endpackage : sum_shift_pkg

/* File: hw/adc_summation_shifter.sv */
// summation/shift accumulator with converter result pacing
`include "sum_shift_consts.svh"
module adc_summation_shifter
  import sum_shift_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // special-function register port
  input  wire sfr_req_t    SFR_REQ,
  output logic      [7:0]  SFR_RDATA,
  // converter control bits held elsewhere
  input  wire logic [6:0]  ACLK_DIVISOR,
  input  wire logic        POLARITY_SELECT,
  input  wire logic        CONVERTER_POWERDOWN,
  input  wire logic        INVALID_FLAG_CLR,
  input  wire logic        SUM_IRQ_ENABLE,
  // converter result path
  output logic             RESULT_STROBE,
  input  wire logic        RESULT_VALID,
  input  wire logic [23:0] RESULT_DATA,
  // status
  output logic             ACCUM_INVALID_FLAG,
  output logic             SUM_IRQ
);
  // ==========================================================
  // state
  state_t      cur_ff;
  state_t      nxt_ff;
  logic [10:0] ratio;
  logic [1:0]  mode;
  logic [2:0]  count_field;
  logic [2:0]  shift_field;
  logic [31:0] sample_ext;
  logic [32:0] sum_wide;
  logic [31:0] operand;
  logic        do_add;
  logic        do_sub;
  logic        overflow;
  logic        bipolar;
  logic        done;

  assign ratio       = {cur_ff.ratio_hi, cur_ff.ratio_lo};
  assign mode        = cur_ff.ctrl[7:6];
  assign count_field = cur_ff.ctrl[5:3];
  assign shift_field = cur_ff.ctrl[2:0];
  assign bipolar     = ~POLARITY_SELECT;

  // ==========================================================
  // next state
  always_comb begin
    nxt_ff        = cur_ff;
    nxt_ff.strobe = 1'b0;
    sample_ext    = bipolar ? {{8{RESULT_DATA[23]}}, RESULT_DATA}
                            : {8'h00, RESULT_DATA};
    operand       = 32'h0000_0000;
    do_add        = 1'b0;
    do_sub        = 1'b0;
    done          = 1'b0;

    // pacing: analog clock, modulator, decimation
    if (CONVERTER_POWERDOWN) begin
      nxt_ff.aclk_cnt = 7'h00;
      nxt_ff.mod_cnt  = 6'h00;
      nxt_ff.dec_cnt  = 11'h000;
    end else if (cur_ff.aclk_cnt >= ACLK_DIVISOR) begin
      nxt_ff.aclk_cnt = 7'h00;
      if (cur_ff.mod_cnt == `MOD_DIV_LAST) begin
        nxt_ff.mod_cnt = 6'h00;
        if (cur_ff.dec_cnt + 11'h001 >= ratio) begin
          nxt_ff.dec_cnt = 11'h000;
          nxt_ff.strobe  = 1'b1;
        end else begin
          nxt_ff.dec_cnt = cur_ff.dec_cnt + 11'h001;
        end
      end else begin
        nxt_ff.mod_cnt = cur_ff.mod_cnt + 6'h01;
      end
    end else begin
      nxt_ff.aclk_cnt = cur_ff.aclk_cnt + 7'h01;
    end

    // staging bytes and ratio writes
    if (SFR_REQ.wr) begin
      case (SFR_REQ.addr)
        `ADDR_RATIO_LO: nxt_ff.ratio_lo     = SFR_REQ.wdata;
        `ADDR_RATIO_HI: nxt_ff.ratio_hi     = SFR_REQ.wdata[2:0];
        `ADDR_SUM_B0:   nxt_ff.hold[7:0]    = SFR_REQ.wdata;
        `ADDR_SUM_B1:   nxt_ff.hold[15:8]   = SFR_REQ.wdata;
        `ADDR_SUM_B2:   nxt_ff.hold[23:16]  = SFR_REQ.wdata;
        `ADDR_SUM_B3:   nxt_ff.hold[31:24]  = SFR_REQ.wdata;
        default: ;
      endcase
    end

    // accumulator work, frozen while powered down
    if (!CONVERTER_POWERDOWN) begin
      if (SFR_REQ.wr && SFR_REQ.addr == `ADDR_SUM_B0 && mode == `MODE_CPU) begin
        operand = {cur_ff.hold[31:8], SFR_REQ.wdata};
        do_add  = count_field == `CNT_CPU_ADD;
        do_sub  = count_field == `CNT_CPU_SUB;
      end else if (RESULT_VALID && mode[0] && !cur_ff.stopped) begin
        operand = sample_ext;
        do_add  = 1'b1;
      end
    end
    sum_wide = do_sub ? {1'b0, cur_ff.acc} - {1'b0, operand}
                      : {1'b0, cur_ff.acc} + {1'b0, operand};
    overflow = bipolar ? (cur_ff.acc[31] ^ sum_wide[31]) &
                         (do_sub ? (cur_ff.acc[31] ^ operand[31])
                                 : ~(cur_ff.acc[31] ^ operand[31]))
                       : sum_wide[32];
    if (do_add || do_sub) begin
      nxt_ff.acc = sum_wide[31:0];
    end
    if (do_add && !do_sub && mode[0]) begin
      nxt_ff.cnt = cur_ff.cnt + 9'h001;
      if (cur_ff.cnt + 9'h001 >= (`COUNT_BASE << count_field)) begin
        nxt_ff.stopped = 1'b1;
        nxt_ff.pend    = 1'b1;
        done           = 1'b1;
        // four-bit amount so that code 7 shifts by eight
        if (mode == `MODE_ACC_SHIFT) begin
          nxt_ff.acc = bipolar ? 32'($signed(sum_wide[31:0]) >>> ({1'b0, shift_field} + 4'h1))
                               : sum_wide[31:0] >> ({1'b0, shift_field} + 4'h1);
        end
      end
    end

    // control register write: clear, shift or restart
    if (SFR_REQ.wr && SFR_REQ.addr == `ADDR_SUM_CTRL && !CONVERTER_POWERDOWN) begin
      nxt_ff.ctrl    = SFR_REQ.wdata;
      nxt_ff.cnt     = 9'h000;
      nxt_ff.stopped = 1'b0;
      if (SFR_REQ.wdata == 8'h00) begin
        nxt_ff.acc = 32'h0000_0000;
      end else if (SFR_REQ.wdata[7:6] == `MODE_SHIFT) begin
        nxt_ff.acc = bipolar ? 32'($signed(cur_ff.acc) >>> ({1'b0, SFR_REQ.wdata[2:0]} + 4'h1))
                             : cur_ff.acc >> ({1'b0, SFR_REQ.wdata[2:0]} + 4'h1);
      end
    end

    // invalid flag: set wins over clear
    if (INVALID_FLAG_CLR) begin
      nxt_ff.invalid = 1'b0;
    end
    if ((do_add || do_sub) && overflow) begin
      nxt_ff.invalid = 1'b1;
    end

    // register reads
    if (SFR_REQ.rd) begin
      case (SFR_REQ.addr)
        `ADDR_RATIO_LO: nxt_ff.rdata = cur_ff.ratio_lo;
        `ADDR_RATIO_HI: nxt_ff.rdata = {5'h00, cur_ff.ratio_hi};
        `ADDR_SUM_CTRL: nxt_ff.rdata = cur_ff.ctrl;
        `ADDR_SUM_B0:   nxt_ff.rdata = cur_ff.acc[7:0];
        `ADDR_SUM_B1:   nxt_ff.rdata = cur_ff.acc[15:8];
        `ADDR_SUM_B2:   nxt_ff.rdata = cur_ff.acc[23:16];
        `ADDR_SUM_B3:   nxt_ff.rdata = cur_ff.acc[31:24];
        default:        nxt_ff.rdata = 8'h00;
      endcase
      // a completion in the same cycle wins over the read
      if (SFR_REQ.addr == `ADDR_SUM_B0 && !done) begin
        nxt_ff.pend = 1'b0;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cur_ff          <= '0;
      cur_ff.ratio_lo <= `RST_RATIO_LO;
      cur_ff.ratio_hi <= `RST_RATIO_HI;
      cur_ff.ctrl     <= `RST_SUM_CTRL;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign SFR_RDATA          = cur_ff.rdata;
  assign RESULT_STROBE      = cur_ff.strobe;
  assign ACCUM_INVALID_FLAG = cur_ff.invalid;
  assign SUM_IRQ            = cur_ff.pend & SUM_IRQ_ENABLE;

  // ==========================================================
  // checks
  a_ratio_form: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    SFR_REQ.wr && SFR_REQ.addr == `ADDR_RATIO_HI |=> ratio[10:8] == $past(SFR_REQ.wdata[2:0]))
    else $error("ratio high bits not taken");
  a_strobe_gap: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    RESULT_STROBE |=> !RESULT_STROBE [*8])
    else $error("result strobes too close");
  a_pd_freeze: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CONVERTER_POWERDOWN |=> $stable(cur_ff.acc))
    else $error("accumulator moved while powered down");
  a_ctrl_clear: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    SFR_REQ.wr && SFR_REQ.addr == `ADDR_SUM_CTRL && SFR_REQ.wdata == 8'h00
      && !CONVERTER_POWERDOWN |=> cur_ff.acc == 32'h0000_0000)
    else $error("control write of zero did not clear");
  a_cpu_add: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    SFR_REQ.wr && SFR_REQ.addr == `ADDR_SUM_B0 && mode == `MODE_CPU
      && count_field == `CNT_CPU_ADD && !CONVERTER_POWERDOWN
      |=> cur_ff.acc == $past(cur_ff.acc) + $past({cur_ff.hold[31:8], SFR_REQ.wdata}))
    else $error("cpu add wrong");
  a_cpu_sub: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    SFR_REQ.wr && SFR_REQ.addr == `ADDR_SUM_B0 && mode == `MODE_CPU
      && count_field == `CNT_CPU_SUB && !CONVERTER_POWERDOWN
      |=> cur_ff.acc == $past(cur_ff.acc) - $past({cur_ff.hold[31:8], SFR_REQ.wdata}))
    else $error("cpu subtract wrong");
  a_read_clears: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    SFR_REQ.rd && SFR_REQ.addr == `ADDR_SUM_B0 && !done |=> !cur_ff.pend)
    else $error("pending stayed after read");
  a_byte_order: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    SFR_REQ.rd && SFR_REQ.addr == `ADDR_SUM_B3 |=> SFR_RDATA == $past(cur_ff.acc[31:24]))
    else $error("top byte read wrong");
  a_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ACCUM_INVALID_FLAG && !INVALID_FLAG_CLR |=> ACCUM_INVALID_FLAG)
    else $error("invalid flag dropped on its own");
  a_stop_count: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    cur_ff.stopped && !SFR_REQ.wr |=> $stable(cur_ff.cnt))
    else $error("count moved after stop");
endmodule : adc_summation_shifter

/* File: verification/result_source.sv */
// converter result path model answering each due strobe
module result_source (
  // clock
  input  wire logic        clk,
  // result handshake
  input  wire logic        strobe,
  input  wire logic [1:0]  lag,
  output logic             valid,
  output logic [23:0]      data
);
  timeunit 1ns;
  timeprecision 1ps;
  int pseed  = 32'h6CA3;
  int wait_q = -1;
  initial valid = 1'b0;
  initial data  = 24'h000000;
  // idle data toggles so it never passes for a result
  always @(negedge clk) begin
    valid <= (wait_q == 0);
    data  <= (wait_q == 0) ? 24'($random(pseed)) : ~data;
    if (strobe) wait_q <= lag;
    else if (wait_q >= 0) wait_q <= wait_q - 1;
  end
endmodule : result_source

/* File: verification/testbench.sv */
// self-checking bench for the summation and shift accumulator
`include "sum_shift_consts.svh"
module testbench
  import sum_shift_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, polarity_select, pd, fclr, irq_en, strobe, valid, flag, irq, stop, pend, bad;
  logic [6:0]  div;
  logic [1:0]  lag;
  logic [23:0] rdat;
  logic [7:0]  rd, ctrl;
  logic [31:0] acc;
  sfr_req_t    req;
  int          n_mismatch = 0, checks = 0, seed = 32'h6CA3, cnt, t;
  logic [7:0]  ra [6] = '{`ADDR_RATIO_LO, `ADDR_RATIO_HI, `ADDR_SUM_CTRL, `ADDR_SUM_B0,
                          `ADDR_SUM_B3, 8'hE0};
  logic [7:0]  rv [6] = '{8'h1B, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};

  adc_summation_shifter i_adc_summation_shifter (.CORE_CLK(clk), .RESET_N(rst_n),
    .SFR_REQ(req), .SFR_RDATA(rd), .ACLK_DIVISOR(div), .POLARITY_SELECT(polarity_select),
    .CONVERTER_POWERDOWN(pd), .INVALID_FLAG_CLR(fclr), .SUM_IRQ_ENABLE(irq_en),
    .RESULT_STROBE(strobe), .RESULT_VALID(valid), .RESULT_DATA(rdat),
    .ACCUM_INVALID_FLAG(flag), .SUM_IRQ(irq));
  result_source i_result_source (.clk(clk), .strobe(strobe), .lag(lag), .valid(valid),
    .data(rdat));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic w);
    // idle edge first, so back-to-back calls never redrive req in one step
    @(negedge clk);
    req = '{a, d, w, !w};
    @(negedge clk);
    req = '0;
  endtask : sfr
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    sfr(a, 8'h00, 1'b0);
    chk("sfr read", rd, e);
    if (a == `ADDR_SUM_B0) pend = 1'b0;
  endtask : rchk
  task automatic add(input logic [31:0] v, input logic sub);
    logic [32:0] s;
    s = sub ? {1'b0, acc} - {1'b0, v} : {1'b0, acc} + {1'b0, v};
    if (polarity_select ? s[32] : (acc[31] == (v[31] ^ sub)) && (s[31] != acc[31])) bad = 1'b1;
    acc = s[31:0];
  endtask : add
  task automatic ctl(input logic [7:0] d);
    sfr(`ADDR_SUM_CTRL, d, 1'b1);
    ctrl = d;
    cnt  = 0;
    stop = 1'b0;
    if (d == 8'h00) acc = 32'h0;
    if (d[7:6] == `MODE_SHIFT) acc = acc >> (d[2:0] + 1);
  endtask : ctl
  task automatic load(input logic [31:0] v);
    for (int i = 3; i >= 0; i--) sfr(8'(`ADDR_SUM_B0 + i), v[8*i +: 8], 1'b1);
    if (ctrl[7:3] == 5'h02) add(v, 1'b0);
    if (ctrl[7:3] == 5'h04) add(v, 1'b1);
  endtask : load
  task automatic racc;
    for (int i = 0; i < 4; i++) rchk(8'(`ADDR_SUM_B0 + i), acc[8*i +: 8]);
    chk("irq", irq, pend & irq_en);
    chk("flag", flag, bad);
  endtask : racc
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // ==========
  // reference model of converter accumulation
  always @(posedge clk) if (valid && ctrl[6] && !stop && !pd) begin
    add(polarity_select ? {8'h00, rdat} : {{8{rdat[23]}}, rdat}, 1'b0);
    cnt++;
    if (cnt == (2 << ctrl[5:3])) begin
      stop = 1'b1;
      pend = 1'b1;
      if (ctrl[7]) acc = acc >> (ctrl[2:0] + 1);
    end
  end

  initial begin
    #600000;
    n_mismatch++;
    results;
  end

  // ==========
  // scenarios
  initial begin
    {rst_n, polarity_select, fclr, div, lag, stop, pend, bad, cnt, ctrl, acc} = '0;
    req = '0;
    pd = 1'b1;
    irq_en = 1'b1;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    foreach (ra[i]) rchk(ra[i], rv[i]);
    sfr(`ADDR_SUM_CTRL, 8'h10, 1'b1);
    sfr(`ADDR_SUM_B0, 8'h01, 1'b1);
    rchk(`ADDR_SUM_CTRL, 8'h00);
    rchk(`ADDR_SUM_B0, 8'h00);
    pd = 1'b0;
    repeat (12) begin
      t = $random(seed);
      polarity_select = t[1];
      ctl(t[0] ? 8'h10 : 8'h20);
      rchk(`ADDR_SUM_CTRL, ctrl);
      load($random(seed));
      racc;
    end
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    bad = 1'b0;
    ctl(8'h00);
    racc;
    polarity_select = 1'b1;
    for (int s = 0; s < 8; s++) begin
      ctl(8'h00);
      ctl(8'h10);
      load($random(seed) & 32'h7FFFFFFF);
      ctl(8'(8'h80 | s));
      racc;
    end
    sfr(`ADDR_RATIO_LO, 8'h01, 1'b1);
    sfr(`ADDR_RATIO_HI, 8'hFF, 1'b1);
    rchk(`ADDR_RATIO_HI, 8'h07);
    sfr(`ADDR_RATIO_HI, 8'h00, 1'b1);
    for (int n = 0; n < 8; n++) begin
      polarity_select = n[0];
      irq_en = (n != 3);
      lag = 2'($random(seed));
      ctl(8'h00);
      ctl({n[0] ? `MODE_ACC_SHIFT : `MODE_ACC, 3'(n), 3'(n)});
      while (!stop) @(negedge clk);
      chk("irq on completion", irq, {31'h0, irq_en});
      repeat (130) @(negedge clk);
      racc;
    end
    div = 7'h01;
    sfr(`ADDR_RATIO_LO, 8'h02, 1'b1);
    repeat (2) @(posedge strobe);
    t = int'($time);
    @(posedge strobe);
    chk("result period", 32'((int'($time) - t) / 10), 32'd256);
    results;
  end
endmodule : testbench
